// *** mps_pkg.sv ***
// package for the motor pre-driver serial slave port
package mps_pkg;
  localparam int          MPS_FRAME_BITS = 16;
  localparam int          MPS_CNT_W      = 5;
  localparam int          MPS_ADDR_W     = 6;
  localparam int          MPS_DATA_W     = 8;
  localparam int          MPS_REG_CNT    = 64;
  // access codes held in the top two bits of the input frame
  localparam logic [1:0]  MPS_RW_WRITE   = 2'h1;
  localparam logic [1:0]  MPS_RW_READ    = 2'h0;
  // field positions in the input frame
  localparam int          MPS_RW_HI      = 15;
  localparam int          MPS_ADDR_HI    = 13;
  localparam int          MPS_ADDR_LO    = 8;
  // fixed output header bits 15..8, fault bit is index 14
  localparam logic [7:0]  MPS_OUT_HDR    = 8'h01;
  localparam int          MPS_FAULT_POS  = 6;
  localparam logic [7:0]  MPS_REG_RST    = 8'h00;
  localparam logic        MPS_FAULT_RST  = 1'b0;
  localparam logic [4:0]  MPS_CNT_RST    = 5'h00;
  localparam logic [15:0] MPS_SHIFT_RST  = 16'h0000;
  // synchroniser reset: chip select high, clock and data low (idle)
  localparam logic [2:0]  MPS_SYNC_RST   = 3'h4;
  // pulse counts: address complete, header sent, counter ceiling
  localparam logic [4:0]  MPS_CNT_ADDR   = 5'h07;
  localparam logic [4:0]  MPS_CNT_HDR    = 5'h08;
  localparam logic [4:0]  MPS_CNT_MAX    = 5'h1f;

  typedef enum logic [1:0] {
    MPS_IDLE  = 2'b00,
    MPS_FRAME = 2'b01,
    MPS_CLOSE = 2'b10
  } mps_state_t;

  // write request toward the register memory
  typedef struct packed {
    logic                  we;
    logic [MPS_ADDR_W-1:0] addr;
    logic [MPS_DATA_W-1:0] data;
  } mps_wreq_t;
endpackage

// *** mps_regmem.sv ***
// register memory of the serial port, registered read data
`timescale 1ns/1ps
module mps_regmem
  import mps_pkg::*;
#(
  parameter int ADDR_W = MPS_ADDR_W,
  parameter int DATA_W = MPS_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata_r
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  // contents reset so reads are defined from the start
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_r[i] <= DATA_W'(MPS_REG_RST);
      end
    end else if (clk_en && we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // read data come from a register, one cycle after the address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= DATA_W'(MPS_REG_RST);
    end else if (clk_en) begin
      rdata_r <= mem_r[raddr];
    end
  end
endmodule

// *** mps_spi_slave.sv ***
// serial slave port of the motor pre-driver, oversampled by core_clk
//
// Behaviour
// R1 - slave only: reacts to host frames, never starts a transfer
// R2 - chip select low frames a transfer, falling starts, rising ends
// R3 - output driven while chip select low, released while high
// R4 - host keeps an idle gap with chip select high between frames
// R5 - host idles clock low and gives exactly sixteen pulses
// R6 - next bit presented on each falling serial clock edge
// R7 - input sampled on each rising serial clock edge
// R8 - host keeps serial clock at or below 4 MHz
// R9 - sixteen input bits received most significant first
// R10 - register written only when exactly sixteen pulses were seen
// R11 - sixteen output bits sent most significant first
// R12 - input: two-bit code (01 write, 00 read), six address, eight data
// R13 - output: 0, fault, five zeros, 1, then eight data bits
// R14 - fault bit shows whether the previous frame had an error
// R15 - pulse count other than sixteen is a frame error
// R16 - read returns addressed register, write stores low input byte
`timescale 1ns/1ps
module mps_spi_slave
  import mps_pkg::*;
#(
  parameter int FRAME_BITS = MPS_FRAME_BITS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  input  wire logic                  sel_b,
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  output logic                       sdo,
  output logic                       sdo_oe,
  output logic                       frame_done,
  output logic                       frame_err_r,
  output logic      [MPS_ADDR_W-1:0] last_waddr_r,
  output logic                       last_wr_r
);
  // elaboration checks: the frame layout is fixed at sixteen bits, and
  // the pulse counter must hold one count past a full frame
  if (FRAME_BITS != MPS_FRAME_BITS) begin : g_bad_len
    $error("frame length other than 16 not supported");
  end
  if ((2 ** MPS_CNT_W) <= (FRAME_BITS + 1)) begin : g_bad_cnt
    $error("pulse counter too narrow for the frame length");
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers: all three pins come from the host's domain
  logic [2:0] sel_s1_r;
  logic [2:0] sel_s2_r;
  logic       sel_d_r;
  logic       sclk_d_r;

  // reset to the idle pin levels, so no false clock edge follows reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_s1_r <= MPS_SYNC_RST;
      sel_s2_r <= MPS_SYNC_RST;
      sel_d_r  <= 1'b1;
      sclk_d_r <= 1'b0;
    end else if (clk_en) begin
      sel_s1_r <= {sel_b, sclk, sdi};
      sel_s2_r <= sel_s1_r;
      sel_d_r  <= sel_s2_r[2];
      sclk_d_r <= sel_s2_r[1];
    end
  end

  // clock edges are taken only inside a frame, from the synchronised levels
  wire sel_q     = sel_s2_r[2];
  wire sclk_q    = sel_s2_r[1];
  wire sdi_q     = sel_s2_r[0];
  wire sel_fall  = sel_d_r && !sel_q;            // [R2]
  wire sel_rise  = !sel_d_r && sel_q;            // [R2]
  wire sclk_rise = !sel_q && sclk_q && !sclk_d_r; // [R7]
  wire sclk_fall = !sel_q && !sclk_q && sclk_d_r; // [R6]

  ////////////////////////////////////////////////////////////////////////
  // frame state, shift registers, pulse count
  mps_state_t                 state_r;
  mps_state_t                 state_nxt;
  logic [FRAME_BITS-1:0]      rx_r;
  logic [FRAME_BITS-1:0]      tx_r;
  logic [MPS_CNT_W-1:0]       cnt_r;
  logic                       fault_r;
  logic [MPS_DATA_W-1:0]      rdata;
  mps_wreq_t                  wreq;

  // no edge of the host clock is trusted outside a frame [R1]
  // close lasts one cycle, so the write pulse cannot repeat
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MPS_IDLE:  if (sel_fall) state_nxt = MPS_FRAME;
      MPS_FRAME: if (sel_rise) state_nxt = MPS_CLOSE;
      MPS_CLOSE: state_nxt = MPS_IDLE;
      default:   state_nxt = MPS_IDLE;
    endcase
  end

  // access-code compare, shared by the frame-end write decision and
  // the early read decision taken once eight bits are in [R12]
  function automatic logic acc_match(input logic [1:0] field,
                                     input logic [1:0] code);
    acc_match = (field == code);
  endfunction

  // frame is good only with exactly sixteen rising edges [R10] [R15]
  wire       cnt_ok   = (cnt_r == MPS_CNT_W'(FRAME_BITS));
  wire       is_write = acc_match(rx_r[MPS_RW_HI -: 2],
                                  MPS_RW_WRITE);       // [R12]
  wire [5:0] rx_addr  = rx_r[MPS_ADDR_HI:MPS_ADDR_LO];          // [R12]
  wire       closing  = (state_r == MPS_FRAME) && sel_rise;

  // write only at frame end, only for a clean write frame [R10] [R16]
  assign wreq.we   = closing && cnt_ok && is_write;
  assign wreq.addr = rx_addr;
  assign wreq.data = rx_r[MPS_DATA_W-1:0];
  assign frame_done = closing;

  // header: 0, fault, 00000, 1 [R13] [R14]
  wire [7:0] hdr = MPS_OUT_HDR | (8'(fault_r) << MPS_FAULT_POS);

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MPS_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // receive shifts msb first on each rising host clock [R7] [R9]
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r  <= MPS_SHIFT_RST;
      cnt_r <= MPS_CNT_RST;
    end else if (clk_en) begin
      if (sel_fall) begin
        cnt_r <= MPS_CNT_RST;
      end else if (sclk_rise && state_r == MPS_FRAME) begin
        rx_r <= {rx_r[FRAME_BITS-2:0], sdi_q};   // [R9]
        // the count saturates, so an overlong frame never wraps to 16
        if (cnt_r != MPS_CNT_MAX) begin
          cnt_r <= cnt_r + 5'h01;                // saturates, stays bad
        end
      end
    end
  end

  // fault of this frame is shown in the next one [R14] [R15]
  // fault and status move only at frame end, never in mid-frame
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_r      <= MPS_FAULT_RST;
      last_wr_r    <= 1'b0;
      last_waddr_r <= '0;
      frame_err_r  <= 1'b0;
    end else if (clk_en && closing) begin
      fault_r      <= !cnt_ok;                   // [R15]
      frame_err_r  <= !cnt_ok;
      last_wr_r    <= wreq.we;
      last_waddr_r <= rx_addr;
    end
  end

  // the read address is complete at the eighth rising edge; the byte
  // is loaded at the eighth falling edge, where bit 7 is due [R16]
  // limitation: a read cut before eight pulses returns no data
  wire [5:0] live_addr    = {rx_r[4:0], sdi_q};
  wire       is_read_live = acc_match(rx_r[7:6], MPS_RW_READ); // [R12]
  wire       load_data    = (cnt_r == MPS_CNT_HDR) && sclk_fall
                            && is_read_live;

  // transmit word: the header is held ready while deselected, so bit 15
  // stands on the pin from the moment the output is enabled; the read
  // byte replaces the top half after the address, else plain shifts
  wire                  tx_shift = sclk_fall && (state_r == MPS_FRAME);
  wire [FRAME_BITS-1:0] tx_hdr   = {hdr, 8'h00};             // [R13]
  wire [FRAME_BITS-1:0] tx_nxt   =
    sel_q     ? tx_hdr :                                     // [R13] [R14]
    load_data ? {rdata, tx_r[7:0]} :                         // [R16]
    tx_shift  ? {tx_r[FRAME_BITS-2:0], 1'b0} :               // [R6] [R11]
    tx_r;

  // transmit register, frozen with the clock enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_r <= MPS_SHIFT_RST;
    end else if (clk_en) begin
      tx_r <= tx_nxt;
    end
  end

  // read address sampled once eight bits are in (code + address)
  logic [5:0] raddr_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      raddr_r <= '0;
    end else if (clk_en && sclk_rise && cnt_r == MPS_CNT_ADDR) begin
      raddr_r <= live_addr;
    end
  end

  mps_regmem #(
    .ADDR_W (MPS_ADDR_W),
    .DATA_W (MPS_DATA_W)
  ) u_mem (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .we       (wreq.we),
    .waddr    (wreq.addr),
    .wdata    (wreq.data),
    .raddr    (raddr_r),
    .rdata_r  (rdata)
  );

  // the three-state pad sits outside; sdo_oe switches its buffer
  // driven only inside a frame, released otherwise [R3]
  assign sdo_oe = !sel_q;
  assign sdo    = tx_r[FRAME_BITS-1];
endmodule

// *** mps_spi_slave_asserts.sv ***
// checker on the pins of the serial slave port
`timescale 1ns/1ps
module mps_spi_slave_asserts #(
  parameter int FRAME_BITS = 16
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       sel_b,
  input wire logic       sclk,
  input wire logic       sdi,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic       frame_done,
  input wire logic       frame_err_r,
  input wire logic [5:0] last_waddr_r,
  input wire logic       last_wr_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // six samples cover the two sync stages that sdo_oe is decoded from
  sequence sel_idle_s; sel_b [*6]; endsequence
  sequence frame_end_s; sel_b ##0 $past(sel_b, 2); endsequence
  oe_off_a: assert property (sel_idle_s |-> !sdo_oe)
    else $error("sdo_oe high while deselected");
  oe_on_a: assert property ($fell(sel_b) |-> ##[2:5] sdo_oe)
    else $error("sdo_oe late after select");
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("frame_done longer than one cycle");
  done_cause_a: assert property
    (frame_done |-> frame_end_s ##0 !$past(sel_b, 6))
    else $error("frame_done without a closed frame");
  idle_quiet_a: assert property
    (sel_b [*8] |-> !frame_done && $stable(last_wr_r))
    else $error("activity while deselected");
  sdo_timing_a: assert property ($changed(sdo) |-> !$past(sclk, 3))
    else $error("sdo moved outside a low clock phase");
  hdr_first_a: assert property ($rose(sdo_oe) |-> !sdo)
    else $error("first output bit not zero");
  write_clean_a: assert property (last_wr_r |-> !frame_err_r)
    else $error("write done on a faulty frame");
  fault_upd_a: assert property
    ($changed(frame_err_r) |-> frame_done || $past(frame_done))
    else $error("fault flag moved outside frame end");
endmodule

bind mps_spi_slave mps_spi_slave_asserts #(.FRAME_BITS(FRAME_BITS)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .sel_b(sel_b),
  .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .frame_done(frame_done), .frame_err_r(frame_err_r),
  .last_waddr_r(last_waddr_r), .last_wr_r(last_wr_r));

// *** mps_host_model.sv ***
// host model: the controller that frames transfers on the serial port
`timescale 1ns/1ps
module mps_host_model (
  input  wire logic core_clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      sel_b,
  output logic      sclk,
  output logic      sdi
);
  // idle levels; data line rests at its pulldown level
  initial begin
    sel_b = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // one frame; a count other than 16 only when a scenario asks for it
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(negedge core_clk);
    sel_b = 1'b0;
    #200;
    // 125 ns period split 65 low / 60 high, so every edge lands on a
    // falling core clock edge; faster than the host limit on purpose,
    // the oversampler needs only four core cycles per level
    for (int i = 0; i < n; i++) begin
      sdi = w[15 - (i % 16)];
      #65 sclk = 1'b1;
      // a released line reads as the inverse of its last value
      r = {r[14:0], sdo_oe ? sdo : ~sdo};
      #60 sclk = 1'b0;
    end
    #100 sel_b = 1'b1;
    sdi = 1'b0;
    #5000;
  endtask
endmodule

// *** mps_spi_slave_tb.sv ***
// testbench of the serial slave port
`timescale 1ns/1ps
module mps_spi_slave_tb
  import mps_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b, sel_b, sclk, sdi, sdo, sdo_oe;
  logic        frame_done, frame_err_r, last_wr_r;
  logic [5:0]  last_waddr_r;
  logic [15:0] r;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #2.5 core_clk = ~core_clk;
  mps_host_model h (.core_clk(core_clk), .sdo(sdo), .sdo_oe(sdo_oe),
    .sel_b(sel_b), .sclk(sclk), .sdi(sdi));
  mps_spi_slave dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
    .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .frame_done(frame_done), .frame_err_r(frame_err_r),
    .last_waddr_r(last_waddr_r), .last_wr_r(last_wr_r));
  task automatic check(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("miscompares %0d samples_checked %0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // quiet port after reset
  task automatic t_reset();
    check("oe idle", {15'h0, sdo_oe}, 16'h0000);
    check("fault rst", {15'h0, frame_err_r}, 16'h0000);
    check("done idle", {15'h0, frame_done}, 16'h0000);
    check("sdo idle", {15'h0, sdo}, 16'h0000);
  endtask
  // unwritten place reads zero, then write and read back top address
  task automatic t_wr_rd();
    h.xfer(16'h0000, 16, r);
    check("rd zero", r, 16'h0100);
    h.xfer(16'h7fa5, 16, r);
    check("wr hdr", {r[15:8], 8'h00}, 16'h0100);
    check("wr stat", {9'h0, last_wr_r, last_waddr_r}, 16'h007f);
    h.xfer(16'h3f00, 16, r);
    check("rd back", r, 16'h01a5);
    check("rd stat", {9'h0, last_wr_r, last_waddr_r}, 16'h003f);
  endtask
  // short and long frames must not write and must raise the fault bit
  task automatic t_bad_cnt();
    for (int n = 15; n <= 17; n += 2) begin
      h.xfer(16'h7f5a, n, r);
      check("err flag", {15'h0, frame_err_r}, 16'h0001);
      h.xfer(16'h3f00, 16, r);
      check("fault rd", r, 16'h41a5);
    end
    h.xfer(16'h3f00, 16, r);
    check("clean rd", r, 16'h01a5);
  endtask
  // codes 10 and 11 neither write nor return data
  task automatic t_codes();
    for (int c = 2; c < 4; c++) begin
      h.xfer({c[1:0], 14'h3f3c}, 16, r);
      check("code rd", r, 16'h0100);
      check("code wr", {15'h0, last_wr_r}, 16'h0000);
    end
    h.xfer(16'h3f00, 16, r);
    check("kept", r, 16'h01a5);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset for three cycles, then the scenarios
  initial begin
    rst_b = 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_wr_rd();
    t_bad_cnt();
    t_codes();
    give_verdict();
  end
  // eleven frames of about 7.3 us each; a hang stops well past that
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
